// >>> design/pau_pkg.sv
`default_nettype none
package pau_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int LS_W   = 6;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PARTNER   = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_EXPANSION = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_STD_LO    = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_STD_HI    = 5'h0F;
    localparam logic [ADDR_W-1:0] OFS_UNIT_STAT = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_SPECIAL   = 5'h11;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LPA_ACK    = 14;
    localparam int EXP_PDF    = 4;
    localparam int EXP_LP_NP  = 3;
    localparam int EXP_NP     = 2;
    localparam int EXP_PR     = 1;
    localparam int EXP_LP_AN  = 0;
    localparam int UST_RW_MSB = 15;
    localparam int UST_RW_LSB = 12;
    localparam int UST_CSDC   = 13;
    localparam int UST_TXFC   = 12;
    localparam int UST_INSYNC = 11;
    localparam int UST_PD100  = 10;
    localparam int UST_PD10   = 9;
    localparam int UST_POL    = 8;
    localparam int UST_SPEED  = 1;
    localparam int UST_DUPLEX = 0;
    localparam int SPC_SCR    = 15;
    localparam int SPC_ENC    = 14;
    localparam int SPC_HPAT   = 13;
    localparam int SPC_P34    = 12;
    localparam int SPC_GOOD   = 11;
    localparam int SPC_TXCS   = 9;
    localparam int SPC_DPD    = 8;
    localparam int SPC_ANLB   = 7;
    localparam int SPC_TRI    = 6;
    localparam int SPC_FILT   = 5;
    localparam int SPC_APOL   = 4;
    localparam int SPC_SQL    = 3;
    localparam int SPC_XSQL   = 2;
    localparam int SPC_LINK   = 1;
    localparam int SPC_JAB    = 0;

    // Line status vector: {insync, pd100, pd10, polarity, speed, duplex}
    localparam int LS_INSYNC  = 5;
    localparam int LS_PD100   = 4;
    localparam int LS_PD10    = 3;
    localparam int LS_POL     = 2;
    localparam int LS_SPEED   = 1;
    localparam int LS_DUPLEX  = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_PARTNER   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_SPECIAL   = 16'h0000;
    localparam logic [3:0]        RST_UST_RW    = 4'h0;
    localparam logic [LS_W-1:0]   RST_LINE_STAT = 6'h18;
    localparam logic [DATA_W-1:0] READ_ZERO     = 16'h0000;

endpackage : pau_pkg
`default_nettype wire

// >>> design/pau_sync.sv
`default_nettype none
module pau_sync #(
    parameter int                 W   = 1,
    parameter logic [W-1:0]       RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    // First stage is read by the second stage only
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST;
            q    <= RST;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : pau_sync
`default_nettype wire

// >>> design/pau_clr_on_read.sv
`default_nettype none
module pau_clr_on_read #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] set,
    input  wire logic         clr,
    output var  logic [W-1:0] q
);

    logic [W-1:0] next_q;

    // A set in the clearing cycle survives for the next read
    assign next_q = (clr ? '0 : q) | set;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

endmodule : pau_clr_on_read
`default_nettype wire

// >>> design/pau_regs.sv
// Functional notes
// - Partner page shown read-only in ability register
// - Acknowledge bit set after partner page received
// - Parallel detection fault latches, clears on read
// - Page received latches, clears on read
// - Expansion capability bits read-only, reset zero
// - Bit 13 enables carrier-sense disconnect
// - Bit 12 enables transmit flow control
// - Bit 11 shows deserializer in sync
// - Power-down bits for both units, reset one
// - Bit 8 shows reversed receive polarity
// - Bits 1:0 show negotiated speed, duplex
// - Scrambler and encoder bypass controls
// - Forced H and 34 transmit patterns
// - Special bit 11 forces 100M link good
// - Special bit 9 disables transmit carrier sense
// - Special bit 8 suppresses dynamic power-down
// - Special bit 7 selects negotiation loopback
// - Special bit 6 tristates line transmit drivers
// - Receive filter bypass, auto polarity disable
// - Squelch test disable, extended squelch enable
// - Link integrity disable, jabber disable
// - Registers 8 to 15 hold nothing
//
// Design decision made here: strobed register access.
`default_nettype none
module pau_regs
    import pau_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              ce,

    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output var  logic [DATA_W-1:0] regRdata,

    // Negotiation engine, same clock
    input  wire logic              anRestart,
    input  wire logic              pageRcvd,
    input  wire logic [DATA_W-1:0] pageWord,
    input  wire logic              parDetFault,
    input  wire logic              partnerAnAble,
    input  wire logic              partnerNpAble,
    input  wire logic              localNpAble,

    // Line status, from outside this clock
    input  wire logic              rxDeserInSync,
    input  wire logic              pwrDown100,
    input  wire logic              pwrDown10,
    input  wire logic              polarityRev,
    input  wire logic              anSpeed100,
    input  wire logic              anFullDuplex,

    // Controls toward the transceiver
    output logic                   csDisconnectEn,
    output logic                   txFlowCtrlEn,
    output logic                   scramblerBypass,
    output logic                   encBypass,
    output logic                   forceHPattern,
    output logic                   force34Pattern,
    output logic                   forceLinkGood,
    output logic                   txCarrierSenseDis,
    output logic                   dynPwrDownDis,
    output logic                   anLoopback,
    output logic                   lineTxTristate,
    output logic                   rxFilterBypass,
    output logic                   autoPolarityDis,
    output logic                   squelchTestDis,
    output logic                   extSquelchEn,
    output logic                   linkIntegrityDis,
    output logic                   jabberDis
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic isAt(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        return a == ofs;
    endfunction : isAt

    logic wrUnit;
    logic wrSpecial;
    logic rdExpansion;
    logic inStdBlock;

    assign wrUnit      = regWr && isAt(regAddr, OFS_UNIT_STAT);
    assign wrSpecial   = regWr && isAt(regAddr, OFS_SPECIAL);
    assign rdExpansion = regRd && isAt(regAddr, OFS_EXPANSION);
    // Reserved standard block: decoded only so it reads as zero
    assign inStdBlock  = (regAddr >= OFS_STD_LO) &&
                         (regAddr <= OFS_STD_HI);

    // ------------------------------------------------------------
    // Line status synchroniser
    // ------------------------------------------------------------
    logic [LS_W-1:0] lineRaw;
    logic [LS_W-1:0] lineStat;

    assign lineRaw = {rxDeserInSync, pwrDown100, pwrDown10,
                      polarityRev, anSpeed100, anFullDuplex};

    // Power-down bits come out of reset as one
    pau_sync #(
        .W   (LS_W),
        .RST (RST_LINE_STAT)
    ) u_line_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .d       (lineRaw),
        .q       (lineStat)
    );

    // ------------------------------------------------------------
    // Partner ability
    // ------------------------------------------------------------
    logic [DATA_W-1:0] partner;
    logic [DATA_W-1:0] next_partner;
    logic [DATA_W-1:0] pageAcked;

    // Acknowledge is ours, not the partner's: force it on capture
    always_comb begin
        pageAcked          = pageWord;
        pageAcked[LPA_ACK] = 1'b1;
    end

    // A restart forgets the old partner so stale data never shows
    assign next_partner = anRestart ? RST_PARTNER :
                          pageRcvd  ? pageAcked   : partner;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            partner <= RST_PARTNER;
        end else if (ce) begin
            partner <= next_partner;
        end
    end

    // ------------------------------------------------------------
    // Expansion register
    // ------------------------------------------------------------
    logic [1:0] evtSet;
    logic [1:0] evtLatch;
    logic       lpNpAble;
    logic       npAble;
    logic       lpAnAble;

    assign evtSet = {parDetFault, pageRcvd};

    // Clear follows the read; the read word already holds the value
    pau_clr_on_read #(
        .W (2)
    ) u_events (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .ce      (ce),
        .set     (evtSet),
        .clr     (rdExpansion),
        .q       (evtLatch)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lpNpAble <= 1'b0;
            npAble   <= 1'b0;
            lpAnAble <= 1'b0;
        end else if (ce) begin
            lpNpAble <= partnerNpAble;
            npAble   <= localNpAble;
            lpAnAble <= partnerAnAble;
        end
    end

    logic [DATA_W-1:0] expWord;

    always_comb begin
        expWord            = READ_ZERO;
        expWord[EXP_PDF]   = evtLatch[1];
        expWord[EXP_LP_NP] = lpNpAble;
        expWord[EXP_NP]    = npAble;
        expWord[EXP_PR]    = evtLatch[0];
        expWord[EXP_LP_AN] = lpAnAble;
    end

    // ------------------------------------------------------------
    // Unit status and control
    // ------------------------------------------------------------
    logic [UST_RW_MSB-UST_RW_LSB:0] unitCtrl;
    logic [DATA_W-1:0]              unitWord;

    // Upper reserved bits are writable and read back as written
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            unitCtrl <= RST_UST_RW;
        end else if (ce && wrUnit) begin
            unitCtrl <= regWdata[UST_RW_MSB:UST_RW_LSB];
        end
    end

    always_comb begin
        unitWord                        = READ_ZERO;
        unitWord[UST_RW_MSB:UST_RW_LSB] = unitCtrl;
        unitWord[UST_INSYNC] = lineStat[LS_INSYNC];
        unitWord[UST_PD100]  = lineStat[LS_PD100];
        unitWord[UST_PD10]   = lineStat[LS_PD10];
        unitWord[UST_POL]    = lineStat[LS_POL];
        unitWord[UST_SPEED]  = lineStat[LS_SPEED];
        unitWord[UST_DUPLEX] = lineStat[LS_DUPLEX];
    end

    assign csDisconnectEn = unitCtrl[UST_CSDC-UST_RW_LSB];
    assign txFlowCtrlEn   = unitCtrl[UST_TXFC-UST_RW_LSB];

    // ------------------------------------------------------------
    // Special control
    // ------------------------------------------------------------
    logic [DATA_W-1:0] special;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            special <= RST_SPECIAL;
        end else if (ce && wrSpecial) begin
            special <= regWdata;
        end
    end

    assign scramblerBypass   = special[SPC_SCR];
    assign encBypass         = special[SPC_ENC];
    assign forceHPattern     = special[SPC_HPAT];
    assign force34Pattern    = special[SPC_P34];
    assign forceLinkGood     = special[SPC_GOOD];
    assign txCarrierSenseDis = special[SPC_TXCS];
    assign dynPwrDownDis     = special[SPC_DPD];
    assign anLoopback        = special[SPC_ANLB];
    assign lineTxTristate    = special[SPC_TRI];
    assign rxFilterBypass    = special[SPC_FILT];
    assign autoPolarityDis   = special[SPC_APOL];
    assign squelchTestDis    = special[SPC_SQL];
    assign extSquelchEn      = special[SPC_XSQL];
    assign linkIntegrityDis  = special[SPC_LINK];
    assign jabberDis         = special[SPC_JAB];

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] readMux;
    logic [DATA_W-1:0] next_rdata;

    // Unmapped and reserved offsets read zero; writes there vanish
    assign readMux =
        isAt(regAddr, OFS_PARTNER)   ? partner  :
        isAt(regAddr, OFS_EXPANSION) ? expWord  :
        isAt(regAddr, OFS_UNIT_STAT) ? unitWord :
        isAt(regAddr, OFS_SPECIAL)   ? special  :
        inStdBlock                   ? READ_ZERO : READ_ZERO;

    // Data stand for the one cycle after the strobe only
    assign next_rdata = regRd ? readMux : READ_ZERO;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= READ_ZERO;
        end else if (ce) begin
            regRdata <= next_rdata;
        end
    end

endmodule : pau_regs
`default_nettype wire

// >>> testbench/pau_regs_assertions.sv
`default_nettype none
module pau_regs_checker
    import pau_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              arst_n,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic              anRestart,
    input wire logic              pageRcvd,
    input wire logic [DATA_W-1:0] pageWord,
    input wire logic              parDetFault,
    input wire logic              csDisconnectEn,
    input wire logic              txFlowCtrlEn,
    input wire logic              scramblerBypass,
    input wire logic              encBypass,
    input wire logic              forceHPattern,
    input wire logic              force34Pattern,
    input wire logic              forceLinkGood
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    wire rdExp = ce && regRd && (regAddr == OFS_EXPANSION);
    wire wrSpc = ce && regWr && (regAddr == OFS_SPECIAL);
    wire wrUst = ce && regWr && (regAddr == OFS_UNIT_STAT);

    a_bypass_write: assert property (
        wrSpc |=> {scramblerBypass, encBypass} == $past(regWdata[15:14]))
        else $error("bypass controls differ from written data");
    a_pattern_write: assert property (
        wrSpc |=> {forceHPattern, force34Pattern} == $past(regWdata[13:12]))
        else $error("pattern controls differ from written data");
    a_unit_write: assert property (
        wrUst |=> {csDisconnectEn, txFlowCtrlEn} == $past(regWdata[13:12]))
        else $error("unit controls differ from written data");
    a_link_hold: assert property (
        !wrSpc |=> $stable(forceLinkGood))
        else $error("link good override changed without a write");
    a_page_ack: assert property (
        ce && pageRcvd && !anRestart ##1 ce && regRd && regAddr == OFS_PARTNER
        |=> regRdata == ($past(pageWord, 2) | 16'h4000))
        else $error("partner ability read differs from received page");
    a_page_latch: assert property (
        ce && pageRcvd ##1 rdExp |=> regRdata[EXP_PR])
        else $error("page received bit not latched");
    a_fault_latch: assert property (
        ce && parDetFault ##1 rdExp |=> regRdata[EXP_PDF])
        else $error("parallel detection fault bit not latched");
    a_read_clear: assert property (
        rdExp && !pageRcvd ##1 rdExp |=> !regRdata[EXP_PR])
        else $error("page received bit survived a read");
    a_std_zero: assert property (
        ce && regRd && regAddr >= OFS_STD_LO && regAddr <= OFS_STD_HI
        |=> regRdata == 16'h0000)
        else $error("standard reserved register read nonzero");
    a_exp_rsvd: assert property (
        rdExp |=> regRdata[15:5] == 11'h000)
        else $error("expansion reserved bits nonzero");

    c_page_read: cover property (ce && pageRcvd ##1 rdExp);
    c_read_twice: cover property (rdExp ##1 rdExp);
    c_spc_write: cover property (wrSpc);
endmodule : pau_regs_checker

bind pau_regs pau_regs_checker i_chk (.sys_clk, .arst_n, .ce, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .anRestart, .pageRcvd, .pageWord, .parDetFault, .csDisconnectEn,
    .txFlowCtrlEn, .scramblerBypass, .encBypass, .forceHPattern, .force34Pattern,
    .forceLinkGood);
`default_nettype wire

// >>> testbench/pau_partner_model.sv
`default_nettype none
module pau_partner_model
    import pau_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              send,
    input  wire logic [DATA_W-1:0] word,
    output logic                   pageRcvd      = 1'b0,
    output logic [DATA_W-1:0]      pageWord      = 16'h0000,
    output logic                   partnerAnAble = 1'b0,
    output logic                   partnerNpAble = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    always @(posedge sys_clk) begin
        pageRcvd <= send;
        // Off the page the word keeps changing, so stale data never looks valid
        pageWord <= send ? word : ~pageWord;
        if (send) begin
            partnerAnAble <= 1'b1;
            partnerNpAble <= word[15];
        end
    end
endmodule : pau_partner_model
`default_nettype wire

// >>> testbench/phy_autoneg_and_special_regs_tb_top.sv
`default_nettype none
module phy_autoneg_and_special_regs_tb_top
    import pau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              sys_clk, arst_n, ce, regWr, regRd, anRestart, parDetFault;
    logic              localNpAble, send, pageRcvd, partnerAnAble, partnerNpAble;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, pageWord, sendWord, rdat, ctl, spc;
    logic [LS_W-1:0]   lineStat;
    logic [3:0]        ustRw;
    logic              csDisconnectEn, txFlowCtrlEn, scramblerBypass, encBypass;
    logic              forceHPattern, force34Pattern, forceLinkGood, txCarrierSenseDis;
    logic              dynPwrDownDis, anLoopback, lineTxTristate, rxFilterBypass;
    logic              autoPolarityDis, squelchTestDis, extSquelchEn, linkIntegrityDis;
    logic              jabberDis;
    int                numErrors, cmpCount;

    assign ctl = {scramblerBypass, encBypass, forceHPattern, force34Pattern, forceLinkGood,
        1'b0, txCarrierSenseDis, dynPwrDownDis, anLoopback, lineTxTristate, rxFilterBypass,
        autoPolarityDis, squelchTestDis, extSquelchEn, linkIntegrityDis, jabberDis};

    pau_regs i_dut (.sys_clk, .arst_n, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .anRestart, .pageRcvd, .pageWord, .parDetFault, .partnerAnAble, .partnerNpAble,
        .localNpAble, .rxDeserInSync(lineStat[LS_INSYNC]), .pwrDown100(lineStat[LS_PD100]),
        .pwrDown10(lineStat[LS_PD10]), .polarityRev(lineStat[LS_POL]),
        .anSpeed100(lineStat[LS_SPEED]), .anFullDuplex(lineStat[LS_DUPLEX]),
        .csDisconnectEn, .txFlowCtrlEn, .scramblerBypass, .encBypass, .forceHPattern,
        .force34Pattern, .forceLinkGood, .txCarrierSenseDis, .dynPwrDownDis, .anLoopback,
        .lineTxTristate, .rxFilterBypass, .autoPolarityDis, .squelchTestDis, .extSquelchEn,
        .linkIntegrityDis, .jabberDis);

    pau_partner_model i_partner (.sys_clk, .send, .word(sendWord), .pageRcvd, .pageWord,
        .partnerAnAble, .partnerNpAble);

    // ------------------------------------------------------------
    // Bus tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [15:0] expUst(input logic [3:0] rw, input logic [5:0] ls);
        return {rw, ls[5:2], 6'h00, ls[1:0]};
    endfunction : expUst

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Strobes stay up until the next call, so calls may follow back to back
    task automatic acc(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        #1 rdat = regRdata;
    endtask : acc

    task automatic testDone();
        $display("checks %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : testDone

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        numErrors++;
        testDone();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {arst_n, regWr, regRd, regAddr, regWdata, anRestart, parDetFault} = '0;
        {localNpAble, send, sendWord} = '0;
        ce = 1'b1;
        lineStat = 6'h18;
        void'($urandom(10));
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        // Read data are taken in the cycle after the strobe, inside acc
        acc(0, 1, OFS_PARTNER, 0);
        check("partner reset", rdat, 16'h0000);
        acc(0, 1, OFS_EXPANSION, 0);
        check("expansion reset", rdat, 16'h0000);
        acc(0, 1, OFS_UNIT_STAT, 0);
        check("unit reset", rdat, 16'h0600);
        acc(0, 1, OFS_SPECIAL, 0);
        check("special reset", rdat, 16'h0000);
        acc(0, 0, 0, 0);
        for (int i = 0; i < 12; i++) begin
            spc = (i == 0) ? 16'hFFFF : 16'($urandom);
            acc(1, 0, OFS_SPECIAL, spc);
            check("controls", ctl, spc & 16'hFBFF);
            ustRw = 4'($urandom);
            lineStat <= 6'($urandom);
            localNpAble <= 1'($urandom);
            acc(1, 0, OFS_UNIT_STAT, {ustRw, 12'hFFF});
            check("unit ctl", 16'({csDisconnectEn, txFlowCtrlEn}), 16'(ustRw[1:0]));
            acc(0, 0, 0, 0);
            acc(0, 1, OFS_SPECIAL, 0);
            check("special", rdat, spc);
            acc(0, 1, OFS_UNIT_STAT, 0);
            check("unit", rdat, expUst(ustRw, lineStat));
            send <= 1'b1;
            sendWord <= (i == 1) ? 16'hFFFF : 16'($urandom);
            acc(0, 0, 0, 0);
            send <= 1'b0;
            acc(0, 0, 0, 0);
            acc(0, 1, OFS_PARTNER, 0);
            check("partner", rdat, sendWord | 16'h4000);
            acc(0, 1, OFS_EXPANSION, 0);
            check("expansion", rdat, {12'h000, sendWord[15], localNpAble, 2'b11});
            acc(0, 1, OFS_EXPANSION, 0);
            check("expansion cleared", rdat & 16'h0012, 16'h0000);
        end
        send <= 1'b1;
        acc(0, 1, OFS_EXPANSION, 0);
        send <= 1'b0;
        acc(0, 1, OFS_EXPANSION, 0);
        check("page in read", rdat & 16'h0002, 16'h0000);
        acc(0, 1, OFS_EXPANSION, 0);
        check("page kept", rdat & 16'h0002, 16'h0002);
        parDetFault <= 1'b1;
        acc(0, 0, 0, 0);
        parDetFault <= 1'b0;
        acc(0, 1, OFS_EXPANSION, 0);
        check("fault latched", rdat & 16'h0010, 16'h0010);
        acc(0, 1, OFS_EXPANSION, 0);
        check("fault cleared", rdat & 16'h0010, 16'h0000);
        anRestart <= 1'b1;
        acc(1, 0, OFS_PARTNER, 16'hFFFF);
        anRestart <= 1'b0;
        acc(1, 0, 5'h0A, 16'hFFFF);
        acc(0, 1, OFS_PARTNER, 0);
        check("partner restart", rdat, 16'h0000);
        acc(0, 1, 5'h0C, 0);
        check("standard block", rdat, 16'h0000);
        acc(0, 1, 5'h1F, 0);
        check("unmapped", rdat, 16'h0000);
        ce <= 1'b0;
        acc(1, 0, OFS_SPECIAL, ~spc);
        ce <= 1'b1;
        acc(0, 0, 0, 0);
        check("frozen controls", ctl, spc & 16'hFBFF);
        testDone();
    end
endmodule : phy_autoneg_and_special_regs_tb_top
`default_nettype wire
